// File: hw/adf_filters.sv
// adf_filters: converter decimation filters with avalon register slave
`timescale 1ns/1ps
`default_nettype none

module adf_filters #(
    parameter int SAMPLE_W = adf_pkg::SAMPLE_W,    // converter sample width
    parameter int DEC_W    = adf_pkg::DEC_W        // decimator sample width
) (
    input  wire logic                        clk_sys,            // crystal clock
    input  wire logic                        rst_b,              // async reset, low
    input  wire logic [adf_pkg::ADDR_W-1:0]  avs_address,        // byte address
    input  wire logic                        avs_read,           // read request
    input  wire logic                        avs_write,          // write request
    input  wire logic [adf_pkg::DATA_W-1:0]  avs_writedata,      // write data
    input  wire logic [3:0]                  avs_byteenable,     // byte lanes
    output logic      [adf_pkg::DATA_W-1:0]  avs_readdata,       // read data
    output logic                             avs_waitrequest,    // stall
    input  wire logic [SAMPLE_W-1:0]         mod_left,           // modulator left
    input  wire logic [SAMPLE_W-1:0]         mod_right,          // modulator right
    input  wire logic [SAMPLE_W-1:0]         mod_mono,           // modulator mono
    input  wire logic                        mod_valid,          // modulator strobe
    input  wire logic [SAMPLE_W-1:0]         ext_left,           // external left
    input  wire logic [SAMPLE_W-1:0]         ext_right,          // external right
    input  wire logic [SAMPLE_W-1:0]         ext_mono,           // external mono
    input  wire logic                        ext_valid,          // external strobe
    input  wire logic [DEC_W-1:0]            demod_left,         // demodulator left
    input  wire logic [DEC_W-1:0]            demod_right,        // demodulator right
    input  wire logic                        demod_valid,        // demodulator strobe
    output logic                             xtal_clk_out,       // crystal clock out
    output logic                             xtal_div2_out,      // crystal / 2
    output logic                             xtal_div4_out,      // crystal / 4
    output logic                             irq                 // level interrupt
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int ACC_W  = SAMPLE_W + 8;           // growth for factor 256
    localparam int DACC_W = DEC_W + 3;              // growth for factor 6

    typedef struct packed {
        logic [15:0]                  ctrl;         // demod_and_filter_control
        logic [15:0]                  cfg;          // converter_filter_config
        logic [adf_pkg::IRQ_W-1:0]    irq_status;   // sticky events
        logic [adf_pkg::IRQ_W-1:0]    irq_mask;     // event mask
        logic [2:0][ACC_W-1:0]        acc;          // left, right, mono sums
        logic [2:0][7:0]              cnt;          // samples in current block
        logic [2:0][SAMPLE_W-1:0]     result;       // latest outputs
        logic [1:0][DACC_W-1:0]       dacc;         // decimator sums
        logic [2:0]                   dcnt;         // decimator sample count
        logic [1:0][DEC_W-1:0]        dresult;      // decimator outputs
        logic [1:0]                   clk_div;      // divider chain
        logic                         rd_ack;       // read answer phase
        logic [adf_pkg::DATA_W-1:0]   rdata;        // read data
        logic                         irq;          // interrupt output
    } adf_state_type;

    adf_state_type st;                              // registered state
    adf_state_type next_st;                         // next state

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // rate code to shift amount, factor = 2**shift
    function automatic logic [3:0] rate_shift(input logic [1:0] code);
        rate_shift = 4'(adf_pkg::RATE_SHIFT_BASE) + {2'h0, code};
    endfunction : rate_shift

    // address decode against a register index
    function automatic logic hit(input logic [adf_pkg::ADDR_W-1:0] a,
                                 input logic [15:0] idx);
        hit = (a[adf_pkg::ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
    endfunction : hit

    // one averaging step; returns the updated accumulator
    function automatic logic [ACC_W-1:0] acc_add(input logic [ACC_W-1:0] a,
                                                 input logic [SAMPLE_W-1:0] x);
        acc_add = ACC_W'($signed(a) + $signed({{8{x[SAMPLE_W-1]}}, x}));
    endfunction : acc_add

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    localparam int IRQ_W_L = adf_pkg::IRQ_W;        // event count, declared before use

    logic                     run;                  // filters powered
    logic [2:0]               ch_en;                // per-channel enable
    logic [2:0][SAMPLE_W-1:0] ch_in;                // per-channel sample
    logic [2:0]               ch_vld;               // per-channel strobe
    logic [2:0][3:0]          ch_sh;                // per-channel shift
    logic [2:0]               ch_done;              // block completed
    logic [1:0][DEC_W-1:0]    d_in;                 // decimator input
    logic                     d_vld;                // decimator strobe
    logic                     d_done;               // decimator completed
    logic [IRQ_W_L-1:0]       ev;                   // events this cycle
    logic [ACC_W-1:0]         sum;                  // completed block sum
    logic [DACC_W-1:0]        dsum;                 // completed decimator sum
    logic [15:0]              wdata;                // masked write data

    always_comb
    begin
        next_st = st;
        run = st.ctrl[adf_pkg::CTRL_INIT];
        ch_en[0] = run & st.cfg[adf_pkg::CFG_STEREO_EN];
        ch_en[1] = ch_en[0];
        ch_en[2] = run & st.cfg[adf_pkg::CFG_MONO_EN];
        ch_sh[0] = rate_shift(st.cfg[adf_pkg::CFG_SRATE_HI:adf_pkg::CFG_SRATE_LO]);
        ch_sh[1] = ch_sh[0];
        ch_sh[2] = rate_shift(st.cfg[adf_pkg::CFG_MRATE_HI:adf_pkg::CFG_MRATE_LO]);
        // external or internal source per channel
        ch_in[0]  = st.ctrl[adf_pkg::CTRL_EXT_LEFT]  ? ext_left  : mod_left;
        ch_vld[0] = st.ctrl[adf_pkg::CTRL_EXT_LEFT]  ? ext_valid : mod_valid;
        ch_in[1]  = st.ctrl[adf_pkg::CTRL_EXT_RIGHT] ? ext_right : mod_right;
        ch_vld[1] = st.ctrl[adf_pkg::CTRL_EXT_RIGHT] ? ext_valid : mod_valid;
        ch_in[2]  = st.ctrl[adf_pkg::CTRL_EXT_MONO]  ? ext_mono  : mod_mono;
        ch_vld[2] = st.ctrl[adf_pkg::CTRL_EXT_MONO]  ? ext_valid : mod_valid;
        // swap filter 2 and 3 inputs
        if (st.cfg[adf_pkg::CFG_SWAP])
        begin
            ch_in  = {ch_in[1], ch_in[2], ch_in[0]};
            ch_vld = {ch_vld[1], ch_vld[2], ch_vld[0]};
        end
        ch_done = 3'h0;
        sum     = '0;

        // each filter steps only on its channel's selected sample strobe
        for (int i = 0; i < 3; i++)
        begin
            if (!ch_en[i])
            begin
                next_st.acc[i] = '0;
                next_st.cnt[i] = 8'h00;
            end
            else if (ch_vld[i])
            begin
                sum = acc_add(st.acc[i], ch_in[i]);
                if ({1'b0, st.cnt[i]} == ((9'h001 << ch_sh[i]) - 9'h001))
                begin
                    // block complete: average and publish
                    next_st.result[i] = SAMPLE_W'($signed(sum) >>> ch_sh[i]);
                    next_st.acc[i]    = '0;
                    next_st.cnt[i]    = 8'h00;
                    ch_done[i]        = 1'b1;
                end
                else
                begin
                    next_st.acc[i] = sum;
                    next_st.cnt[i] = st.cnt[i] + 8'h01;
                end
            end
        end

        if (st.cfg[adf_pkg::CFG_DSEL_HI:adf_pkg::CFG_DSEL_LO] == adf_pkg::DSEL_DEMOD)
        begin
            d_in  = {demod_right, demod_left};
            d_vld = demod_valid;
        end
        else if (st.cfg[adf_pkg::CFG_DSEL_HI:adf_pkg::CFG_DSEL_LO] == adf_pkg::DSEL_STEREO)
        begin
            // cascade from stereo outputs, top bits
            d_in  = {next_st.result[1][SAMPLE_W-1 -: DEC_W],
                     next_st.result[0][SAMPLE_W-1 -: DEC_W]};
            d_vld = ch_done[0];
        end
        else
        begin
            // mono feeds both sides
            d_in  = {2{next_st.result[2][SAMPLE_W-1 -: DEC_W]}};
            d_vld = ch_done[2];
        end
        d_done = 1'b0;
        dsum   = '0;
        // decimate by 6 on 18-bit samples
        if (!(run & st.cfg[adf_pkg::CFG_DEC_EN]))
        begin
            next_st.dacc = '0;
            next_st.dcnt = 3'h0;
        end
        else if (d_vld)
        begin
            for (int j = 0; j < 2; j++)
            begin
                dsum = DACC_W'($signed(st.dacc[j]) + $signed({{3{d_in[j][DEC_W-1]}}, d_in[j]}));
                if (st.dcnt == adf_pkg::DEC_FACTOR - 3'h1)
                begin
                    next_st.dresult[j] = DEC_W'($signed(dsum) / $signed({1'b0, adf_pkg::DEC_FACTOR}));
                    next_st.dacc[j]    = '0;
                end
                else
                begin
                    next_st.dacc[j] = dsum;
                end
            end
            d_done       = (st.dcnt == adf_pkg::DEC_FACTOR - 3'h1);
            next_st.dcnt = d_done ? 3'h0 : st.dcnt + 3'h1;
        end

        ev = '0;
        ev[adf_pkg::IRQ_STEREO] = ch_done[0];
        ev[adf_pkg::IRQ_MONO]   = ch_done[2];
        ev[adf_pkg::IRQ_DEC]    = d_done;

        next_st.clk_div = st.clk_div + 2'h1;

        // register writes, low 16 bits carry data
        wdata = avs_writedata[15:0];
        for (int b = 0; b < 2; b++)
        begin
            if (!avs_byteenable[b])
            begin
                wdata[b*8 +: 8] = 8'h00;
            end
        end
        if (avs_write)
        begin
            if (hit(avs_address, adf_pkg::IDX_CTRL))
            begin
                for (int b = 0; b < 2; b++)
                begin
                    if (avs_byteenable[b])
                    begin
                        next_st.ctrl[b*8 +: 8] = wdata[b*8 +: 8];
                    end
                end
            end
            if (hit(avs_address, adf_pkg::IDX_CFG))
            begin
                for (int b = 0; b < 2; b++)
                begin
                    if (avs_byteenable[b])
                    begin
                        next_st.cfg[b*8 +: 8] = wdata[b*8 +: 8];
                    end
                end
            end
            if (hit(avs_address, adf_pkg::IDX_IRQ_MASK))
            begin
                next_st.irq_mask = wdata[IRQ_W_L-1:0];
            end
            if (hit(avs_address, adf_pkg::IDX_IRQ_STATUS))
            begin
                // write one to clear
                next_st.irq_status = st.irq_status & ~wdata[IRQ_W_L-1:0];
            end
        end
        // new events win over a clear in the same cycle
        next_st.irq_status = next_st.irq_status | ev;
        if (!run)
        begin
            next_st.irq_status = '0;
        end

        // read answer one cycle after the request
        next_st.rd_ack = avs_read & ~st.rd_ack;
        if (avs_read && !st.rd_ack)
        begin
            unique case (1'b1)
                hit(avs_address, adf_pkg::IDX_CTRL):       next_st.rdata = {16'h0000, st.ctrl};
                hit(avs_address, adf_pkg::IDX_CFG):        next_st.rdata = {16'h0000, st.cfg};
                hit(avs_address, adf_pkg::IDX_LEFT_HIGH):  next_st.rdata = {16'h0000, st.result[0][23:8]};
                hit(avs_address, adf_pkg::IDX_LEFT_LOW):   next_st.rdata = {16'h0000, st.result[0][7:0], 8'h00};
                hit(avs_address, adf_pkg::IDX_RIGHT_HIGH): next_st.rdata = {16'h0000, st.result[1][23:8]};
                hit(avs_address, adf_pkg::IDX_RIGHT_LOW):  next_st.rdata = {16'h0000, st.result[1][7:0], 8'h00};
                hit(avs_address, adf_pkg::IDX_MONO_HIGH):  next_st.rdata = {16'h0000, st.result[2][23:8]};
                hit(avs_address, adf_pkg::IDX_MONO_LOW):   next_st.rdata = {16'h0000, st.result[2][7:0], 8'h00};
                hit(avs_address, adf_pkg::IDX_DL_HIGH):    next_st.rdata = {16'h0000, st.dresult[0][17:2]};
                hit(avs_address, adf_pkg::IDX_DL_LOW):     next_st.rdata = {16'h0000, st.dresult[0][1:0], 14'h0000};
                hit(avs_address, adf_pkg::IDX_DR_HIGH):    next_st.rdata = {16'h0000, st.dresult[1][17:2]};
                hit(avs_address, adf_pkg::IDX_DR_LOW):     next_st.rdata = {16'h0000, st.dresult[1][1:0], 14'h0000};
                hit(avs_address, adf_pkg::IDX_IRQ_STATUS): next_st.rdata = {29'h00000000, st.irq_status};
                hit(avs_address, adf_pkg::IDX_IRQ_MASK):   next_st.rdata = {29'h00000000, st.irq_mask};
                default:                                   next_st.rdata = 32'h00000000;
            endcase
        end

        next_st.irq = |(next_st.irq_status & next_st.irq_mask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // init clear empties every filter at once, so a set restarts them in step
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st      <= '0;
            st.ctrl <= adf_pkg::CTRL_RESET;
            st.cfg  <= adf_pkg::CFG_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata    = st.rdata;
    // writes never stall; reads wait one cycle for data
    assign avs_waitrequest = avs_read & ~st.rd_ack;
    // forwarded crystal clock and divided copies
    assign xtal_clk_out    = clk_sys;
    assign xtal_div2_out   = st.clk_div[0];
    assign xtal_div4_out   = st.clk_div[1];
    assign irq             = st.irq;

endmodule : adf_filters

`default_nettype wire

// File: hw/adf_pkg.sv
// adf_pkg: constants for the audio converter decimation filter block
package adf_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;                    // byte address width
    localparam int DATA_W = 32;                    // avalon data width
    localparam int REG_W  = 16;                    // register width

    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_CTRL       = 16'hFE40; // demod_and_filter_control
    localparam logic [15:0] IDX_CFG        = 16'hFE41; // converter_filter_config
    localparam logic [15:0] IDX_LEFT_LOW   = 16'hFE46; // left sample bits 7:0
    localparam logic [15:0] IDX_LEFT_HIGH  = 16'hFE47; // left sample bits 23:8
    localparam logic [15:0] IDX_RIGHT_LOW  = 16'hFE48; // right sample bits 7:0
    localparam logic [15:0] IDX_RIGHT_HIGH = 16'hFE49; // right sample bits 23:8
    localparam logic [15:0] IDX_MONO_LOW   = 16'hFE4A; // mono sample bits 7:0
    localparam logic [15:0] IDX_MONO_HIGH  = 16'hFE4B; // mono sample bits 23:8
    localparam logic [15:0] IDX_DL_LOW     = 16'hFE4E; // decimated left bits 1:0
    localparam logic [15:0] IDX_DL_HIGH    = 16'hFE4F; // decimated_left_high
    localparam logic [15:0] IDX_DR_LOW     = 16'hFE50; // decimated right bits 1:0
    localparam logic [15:0] IDX_DR_HIGH    = 16'hFE51; // decimated_right_high
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hFE5C; // sticky event flags
    localparam logic [15:0] IDX_IRQ_MASK   = 16'hFE5D; // event mask

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CFG_RESET  = 16'h0000;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_EXT_RIGHT = 14;            // ext_in_right
    localparam int CTRL_EXT_LEFT  = 13;            // ext_in_left
    localparam int CTRL_EXT_MONO  = 12;            // ext_in_mono
    localparam int CTRL_INIT      = 6;             // filter_init

    // ------------------------------------------------------------
    // config register fields
    // ------------------------------------------------------------
    localparam int CFG_SWAP       = 9;             // swap_ch2_ch3
    localparam int CFG_DSEL_HI    = 8;             // decimator_input_select msb
    localparam int CFG_DSEL_LO    = 7;             // decimator_input_select lsb
    localparam int CFG_MRATE_HI   = 6;             // mono_rate_select msb
    localparam int CFG_MRATE_LO   = 5;             // mono_rate_select lsb
    localparam int CFG_SRATE_HI   = 4;             // stereo_rate_select msb
    localparam int CFG_SRATE_LO   = 3;             // stereo_rate_select lsb
    localparam int CFG_DEC_EN     = 2;             // decimator_enable
    localparam int CFG_MONO_EN    = 1;             // mono_filter_enable
    localparam int CFG_STEREO_EN  = 0;             // stereo_filter_enable

    // ------------------------------------------------------------
    // interrupt status bits
    // ------------------------------------------------------------
    localparam int IRQ_STEREO = 0;                 // stereo pair new sample
    localparam int IRQ_MONO   = 1;                 // mono new sample
    localparam int IRQ_DEC    = 2;                 // decimator new sample
    localparam int IRQ_W      = 3;

    // ------------------------------------------------------------
    // sample formats and decimation
    // ------------------------------------------------------------
    localparam int SAMPLE_W   = 24;                // converter sample width
    localparam int DEC_W      = 18;                // decimator sample width
    localparam int ACC_W      = 32;                // accumulator, 24 + 8 growth
    localparam int DACC_W     = 21;                // decimator accumulator
    localparam int RATE_SHIFT_BASE = 5;            // code 00 -> factor 32
    localparam logic [2:0] DEC_FACTOR = 3'h6;      // decimate by 6

    // decimator input select codes
    localparam logic [1:0] DSEL_DEMOD  = 2'h0;
    localparam logic [1:0] DSEL_STEREO = 2'h1;

endpackage : adf_pkg

// File: testbench/adf_filters_sva.sv
// adf_filters_sva: port assertions for the decimation filter block
`timescale 1ns/1ps
`default_nettype none
module adf_filters_sva (
    input wire logic        clk_sys,         // clock
    input wire logic        rst_b,           // reset
    input wire logic [17:0] avs_address,     // address
    input wire logic        avs_read,        // read
    input wire logic        avs_write,       // write
    input wire logic [31:0] avs_writedata,   // wdata
    input wire logic [31:0] avs_readdata,    // rdata
    input wire logic        avs_waitrequest, // stall
    input wire logic        xtal_div2_out,   // xtal/2
    input wire logic        xtal_div4_out,   // xtal/4
    input wire logic        irq              // interrupt
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_div2_toggle: assert property ($past(rst_b) |-> xtal_div2_out != $past(xtal_div2_out))
        else $error("half clock stalled");
    a_div4_period: assert property ($rose(xtal_div4_out) |=> xtal_div4_out ##1 !xtal_div4_out)
        else $error("quarter clock wrong");
    a_read_waits: assert property (avs_read && !$past(avs_read && avs_waitrequest) |-> avs_waitrequest)
        else $error("read answered early");
    a_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read answer late");
    a_idle_nowait: assert property (!avs_read |-> !avs_waitrequest)
        else $error("stall without read");
    a_data_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read data set");
    a_init_quiet: assert property (avs_write && avs_address == 18'h3F900 && !avs_writedata[6]
        |-> ##2 !irq[*3])
        else $error("interrupt with filters down");
    a_mask_quiet: assert property (avs_write && avs_address == 18'h3F974 && avs_writedata[2:0] == 3'h0
        |-> ##2 !irq)
        else $error("masked interrupt seen");
    c_irq: cover property ($rose(irq));
    c_read: cover property (avs_read && !avs_waitrequest);
    c_div4: cover property ($rose(xtal_div4_out));
endmodule : adf_filters_sva
`default_nettype wire

// File: testbench/adf_filters_tb.sv
// adf_filters_tb: register-level test of the decimation filters
`timescale 1ns/1ps
`default_nettype none
module adf_filters_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_sys = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, mv, ev, dv, irq, xc;
    logic [17:0] avs_address = 18'h00000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rq;
    logic avs_waitrequest;
    logic [23:0] ml = 24'h111111, mr = 24'h222222, mm = 24'h333333; // modulator samples
    logic [23:0] el = 24'h4A5B6C, er = 24'h555555, em = 24'h666666; // external samples
    logic [17:0] dm = 18'h2ABCD; // demodulator sample
    int miscompares = 0;
    int checked = 0;
    always #5 clk_sys = ~clk_sys;
    adf_filters i_adf_filters (.clk_sys, .rst_b, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .mod_left(ml),
        .mod_right(mr), .mod_mono(mm), .mod_valid(mv), .ext_left(el), .ext_right(er),
        .ext_mono(em), .ext_valid(ev), .demod_left(dm), .demod_right(dm), .demod_valid(dv),
        .xtal_clk_out(xc), .xtal_div2_out(), .xtal_div4_out(), .irq);
    adf_source_model i_adf_source_model (.clk_sys, .rst_b, .mod_valid(mv), .ext_valid(ev),
        .demod_valid(dv));
    task automatic finish_test;
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // request held until waitrequest is seen low; a hang ends the run
    task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] wd);
        int n;
        @(posedge clk_sys);
        avs_write <= w;
        avs_read <= ~w;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {16'h0000, wd};
        n = 0;
        // waitrequest and read data are looked at in the edge's own time step,
        // before any update of that edge lands
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        rq = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            chk(32'h0, 32'h1);
            finish_test;
        end
    endtask : bus
    task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0000);
        chk(rq, {16'h0000, exp});
    endtask : rd
    // edges until the interrupt rises, bounded
    task automatic wirq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 2000)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (irq !== 1'b1)
        begin
            chk(32'h0, 32'h1);
            finish_test;
        end
    endtask : wirq
    initial
    begin
        int n;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(adf_pkg::IDX_CTRL, 16'h0000);
        rd(adf_pkg::IDX_CFG, 16'h0000);
        bus(1'b1, adf_pkg::IDX_IRQ_MASK, 16'h0004);
        bus(1'b1, adf_pkg::IDX_CFG, 16'h0087);
        repeat (150) @(posedge clk_sys);
        rd(adf_pkg::IDX_IRQ_STATUS, 16'h0000);
        // analog front end taken as already set up by software
        bus(1'b1, adf_pkg::IDX_CTRL, 16'h2040);
        wirq(n);
        rd(adf_pkg::IDX_IRQ_STATUS, 16'h0007);
        rd(adf_pkg::IDX_LEFT_HIGH, el[23:8]);
        rd(adf_pkg::IDX_LEFT_LOW, {el[7:0], 8'h00});
        rd(adf_pkg::IDX_RIGHT_HIGH, mr[23:8]);
        rd(adf_pkg::IDX_MONO_HIGH, mm[23:8]);
        rd(adf_pkg::IDX_DL_HIGH, el[23:8]);
        rd(adf_pkg::IDX_DL_LOW, {el[7:6], 14'h0000});
        rd(adf_pkg::IDX_DR_HIGH, mr[23:8]);
        bus(1'b1, adf_pkg::IDX_CFG, 16'h0000);
        bus(1'b1, adf_pkg::IDX_IRQ_STATUS, 16'h0007);
        rd(adf_pkg::IDX_IRQ_STATUS, 16'h0000);
        // swapped right input, every rate code, restart by init
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, adf_pkg::IDX_CTRL, 16'h0000);
            rd(adf_pkg::IDX_IRQ_STATUS, 16'h0000);
            bus(1'b1, adf_pkg::IDX_CFG, 16'h0201 | 16'(c << 5) | 16'(c << 3));
            bus(1'b1, adf_pkg::IDX_IRQ_MASK, 16'h0001);
            bus(1'b1, adf_pkg::IDX_CTRL, 16'h0040);
            wirq(n);
            chk({31'h0, n > (2 << (5 + c)) - 4 && n < (2 << (5 + c)) + 4}, 32'h1);
            rd(adf_pkg::IDX_RIGHT_HIGH, mm[23:8]);
        end
        // remaining decimator input codes
        for (int d = 0; d < 4; d++)
        begin
            if (d != 1)
            begin
                bus(1'b1, adf_pkg::IDX_CTRL, 16'h0000);
                bus(1'b1, adf_pkg::IDX_CFG, 16'h0006 | 16'(d << 7));
                bus(1'b1, adf_pkg::IDX_IRQ_MASK, 16'h0004);
                // stereo external inputs stay off while the demodulator feeds
                bus(1'b1, adf_pkg::IDX_CTRL, 16'h0040);
                wirq(n);
                rd(adf_pkg::IDX_DL_HIGH, d == 0 ? dm[17:2] : mm[23:8]);
                rd(adf_pkg::IDX_DR_HIGH, d == 0 ? dm[17:2] : mm[23:8]);
            end
        end
        bus(1'b1, adf_pkg::IDX_DL_HIGH, 16'hFFFF);
        rd(adf_pkg::IDX_DL_HIGH, mm[23:8]);
        bus(1'b1, 16'hFE60, 16'h1234);
        rd(16'hFE60, 16'h0000);
        // status still holds the decimator flag, so only the mask keeps irq low
        bus(1'b1, adf_pkg::IDX_IRQ_MASK, 16'h0000);
        repeat (4) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        #1;
        chk({31'h0, xc}, {31'h0, clk_sys});
        finish_test;
    end
endmodule : adf_filters_tb
bind adf_filters adf_filters_sva i_adf_filters_sva (.clk_sys, .rst_b, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .xtal_div2_out, .xtal_div4_out,
    .irq);
`default_nettype wire

// File: testbench/adf_source_model.sv
// adf_source_model: strobes of the converter and demodulator sample streams
`timescale 1ns/1ps
`default_nettype none
module adf_source_model #(
    parameter int PER = 2          // strobe period, clocks
) (
    input  wire logic clk_sys,     // crystal clock
    input  wire logic rst_b,       // reset
    output logic      mod_valid,   // modulator strobe
    output logic      ext_valid,   // external strobe
    output logic      demod_valid  // demodulator strobe
);
    int cnt; // clocks in period
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            cnt <= 0;
        else
            cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    end
    assign mod_valid = rst_b && cnt == PER - 1;
    assign ext_valid = mod_valid;
    assign demod_valid = mod_valid;
endmodule : adf_source_model
`default_nettype wire
